// File: verilog/bit_test_pkg.sv
// constants for the bit-test / clear-register execute block
`default_nettype none
package bit_test_pkg;
    localparam int WORD_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    // opcode field positions
    localparam int OP_CLASS_HI = 13;
    localparam int OP_CLASS_LO = 12;
    localparam int OP_SUB_HI = 11;
    localparam int OP_SUB_LO = 10;
    localparam int OP_BIT_HI = 9;
    localparam int OP_BIT_LO = 7;
    localparam int OP_CLR_HI = 13;
    localparam int OP_CLR_LO = 7;
    localparam int OP_ADDR_HI = 6;
    localparam int OP_ADDR_LO = 0;
    // opcode patterns
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [1:0] SUB_SKIP_CLEAR = 2'h2;
    localparam logic [1:0] SUB_SKIP_SET = 2'h3;
    localparam logic [6:0] CLEAR_FILE_PATTERN = 7'h03;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;
    localparam logic [13:0] NO_OPERATION_WORD = 14'h0000;

    typedef enum logic [1:0] {
        ST_EXECUTE = 2'b00,
        ST_SKIP = 2'b01
    } exec_state_t;
endpackage
`default_nettype wire

// File: verilog/bit_test_decode.sv
// opcode decoder for the three supported instructions
`default_nettype none
module bit_test_decode
    import bit_test_pkg::*;
(
    input wire logic [WORD_W-1:0] word,
    output logic is_skip_clear,
    output logic is_skip_set,
    output logic is_clear_file,
    output logic [ADDR_W-1:0] file_addr,
    output logic [BIT_SEL_W-1:0] bit_sel
);
    always_comb begin
        is_skip_clear = word[OP_CLASS_HI:OP_CLASS_LO] == CLASS_BIT &&
            word[OP_SUB_HI:OP_SUB_LO] == SUB_SKIP_CLEAR;
        is_skip_set = word[OP_CLASS_HI:OP_CLASS_LO] == CLASS_BIT &&
            word[OP_SUB_HI:OP_SUB_LO] == SUB_SKIP_SET;
        is_clear_file = word[OP_CLR_HI:OP_CLR_LO] == CLEAR_FILE_PATTERN;
        file_addr = word[OP_ADDR_HI:OP_ADDR_LO];
        bit_sel = word[OP_BIT_HI:OP_BIT_LO];
    end
endmodule
`default_nettype wire

// File: verilog/bit_test_skip_clear_exec.sv
// execute stage for bit-test skips and clear-file-register
// What this block does
// - skip-if-bit-clear skips the next instruction when the chosen bit is zero.
// - a taken skip discards the prefetched word; no-operation runs, two cycles.
// - skip-if-bit-set skips the next instruction when the chosen bit is one.
// - clear-file-register writes 00h to the addressed register in one cycle.
// - clear-file-register always sets the zero flag.
`default_nettype none
module bit_test_skip_clear_exec
    import bit_test_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [ADDR_W-1:0] file_raddr,
    output logic file_we,
    output logic [ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic zero_set,
    output logic discard,
    output logic nop_exec,
    output logic busy
);
    // file_raddr is combinational from the decode so the operand is read
    // in the same cycle; all other outputs are registered
    typedef struct packed {
        exec_state_t state;
        logic busy;
        logic we;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic zset;
        logic disc;
        logic no_operation;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic is_sc;
    logic is_ss;
    logic is_cf;
    logic [ADDR_W-1:0] addr;
    logic [BIT_SEL_W-1:0] bsel;
    logic bit_val;
    logic accept;
    logic take_skip;
    logic take_clear;

    // the selector must reach every bit of the operand and no further
    if (DATA_W != (1 << BIT_SEL_W)) begin : g_sel_check
        $error("bit selector width does not match data width");
    end

    if (ADDR_W != OP_ADDR_HI - OP_ADDR_LO + 1) begin : g_addr_check
        $error("address width does not match its opcode field");
    end

    if (BIT_SEL_W != OP_BIT_HI - OP_BIT_LO + 1) begin : g_bit_check
        $error("bit select width does not match its opcode field");
    end

    if (WORD_W != OP_CLASS_HI + 1) begin : g_word_check
        $error("instruction word width does not match opcode layout");
    end

    if (DATA_W != $bits(CLEAR_VALUE)) begin : g_clear_check
        $error("clear value width does not match data width");
    end

    // one bit of the operand, chosen by the three-bit selector
    function automatic logic pick_bit(
        input logic [DATA_W-1:0] value,
        input logic [BIT_SEL_W-1:0] sel
    );
        pick_bit = value[sel];
    endfunction

    // both tests share one skip path; only the polarity differs
    function automatic logic skip_wanted(
        input logic clear_test,
        input logic set_test,
        input logic tested
    );
        skip_wanted = (clear_test && !tested) || (set_test && tested);
    endfunction

    bit_test_decode u_decode (
        .word(instr_word),
        .is_skip_clear(is_sc),
        .is_skip_set(is_ss),
        .is_clear_file(is_cf),
        .file_addr(addr),
        .bit_sel(bsel)
    );

    assign file_raddr = addr;
    assign bit_val = pick_bit(file_rdata, bsel);

    // a word offered in the skip slot is never accepted
    assign accept = instr_valid && cur.state == ST_EXECUTE;
    assign take_skip = accept && skip_wanted(is_sc, is_ss, bit_val);
    assign take_clear = accept && is_cf;

    always_comb begin
        next_cur = cur;
        next_cur.busy = 1'b0;
        next_cur.we = 1'b0;
        next_cur.zset = 1'b0;
        next_cur.disc = 1'b0;
        next_cur.no_operation = 1'b0;
        case (cur.state)
            ST_EXECUTE: begin
                if (take_skip) begin
                    // prefetched word is dropped, skip occupies a cycle
                    next_cur.disc = 1'b1;
                    next_cur.busy = 1'b1;
                    next_cur.state = ST_SKIP;
                end
                if (take_clear) begin
                    next_cur.we = 1'b1;
                    next_cur.waddr = addr;
                    next_cur.wdata = CLEAR_VALUE;
                    next_cur.zset = 1'b1;
                end
                // bit tests never reach the flag path
                if (take_skip) begin
                    next_cur.zset = 1'b0;
                end
            end
            ST_SKIP: begin
                // instruction word in this slot is ignored
                next_cur.no_operation = 1'b1;
                next_cur.state = ST_EXECUTE;
            end
            default: begin
                next_cur.state = ST_EXECUTE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cur <= '{state: ST_EXECUTE, busy: 1'b0, we: 1'b0, waddr: '0,
                     wdata: CLEAR_VALUE, zset: 1'b0, disc: 1'b0,
                     no_operation: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign file_we = cur.we;
    assign file_waddr = cur.waddr;
    assign file_wdata = cur.wdata;
    assign zero_set = cur.zset;
    assign discard = cur.disc;
    assign nop_exec = cur.no_operation;
    assign busy = cur.busy;
endmodule
`default_nettype wire

// File: verif/bit_test_exec_props.sv
// assertions for the bit-test / clear execute block
`default_nettype none
module bit_test_exec_props
    import bit_test_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic [ADDR_W-1:0] file_raddr,
    input wire logic file_we,
    input wire logic [ADDR_W-1:0] file_waddr,
    input wire logic [DATA_W-1:0] file_wdata,
    input wire logic zero_set,
    input wire logic discard,
    input wire logic nop_exec,
    input wire logic busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic tst = instr_valid && !busy && instr_word[13:11] == 3'h3;
    wire logic hit = tst && file_rdata[instr_word[9:7]] == instr_word[10];
    wire logic clr = instr_valid && !busy && instr_word[13:7] == 7'h03;
    a_skip_take: assert property (hit |=> discard ##1 nop_exec)
        else $error("taken skip missing");
    a_skip_cause: assert property (discard |-> $past(hit))
        else $error("discard without cause");
    a_clear_write: assert property (clr |=> file_we &&
        file_wdata == 8'h00 && file_waddr == $past(instr_word[6:0]))
        else $error("clear write wrong");
    a_clear_zero: assert property (clr |=> zero_set)
        else $error("zero flag not set");
    a_test_flags: assert property (tst |=> !zero_set && !file_we)
        else $error("bit test touched flags");
    a_read_addr: assert property (file_raddr == instr_word[6:0])
        else $error("read address wrong");
    a_slot_ignored: assert property (busy |=>
        !file_we && !zero_set && !discard && nop_exec)
        else $error("skip slot not ignored");
    a_busy_skip: assert property (discard |-> busy)
        else $error("discard without busy");
endmodule
bind bit_test_skip_clear_exec bit_test_exec_props i_props (.clk_sys,
    .reset, .instr_valid, .instr_word, .file_rdata, .file_raddr, .file_we,
    .file_waddr, .file_wdata, .zero_set, .discard, .nop_exec, .busy);
`default_nettype wire

// File: verif/bit_test_skip_clear_exec_bench.sv
// bench for the bit-test / clear execute block
`default_nettype none
module bit_test_skip_clear_exec_bench;
    import bit_test_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 0, reset = 1, instr_valid = 0, we, zs, dc, no_operation, bsy;
    logic [13:0] word = 0;
    logic [7:0] rd = 0, wd;
    logic [6:0] ra, wa;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    bit_test_skip_clear_exec i_bit_test_skip_clear_exec (.clk_sys, .reset,
        .instr_valid, .instr_word(word), .file_rdata(rd), .file_raddr(ra),
        .file_we(we), .file_waddr(wa), .file_wdata(wd), .zero_set(zs),
        .discard(dc), .nop_exec(no_operation), .busy(bsy));
    always #12.5 clk_sys = ~clk_sys;
    // hang guard, far above the roughly 116 cycles needed
    always @(posedge clk_sys) if (++cyc > 2000) begin
        error_cnt++;
        complete_run();
    end
    task chk(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task issue(input logic [13:0] w, input logic [7:0] r);
        word = w;
        rd = r;
        instr_valid = 1;
        @(posedge clk_sys) #2 instr_valid = 0;
    endtask
    task t_skip(input bit set);
        for (int b = 0; b < 8; b++) for (int h = 0; h < 2; h++) begin
            issue({3'h3, set, 3'(b), 7'(b * 18)},
                (8'h01 << b) ^ {8{1'(h) ^ set}});
            chk("discard", dc, 8'(h));
            chk("busy", bsy, 8'(h));
            chk("zero_set", zs, 0);
            chk("file_we", we, 0);
            @(posedge clk_sys) #2 chk("nop_exec", no_operation, 8'(h));
            chk("busy_end", bsy, 0);
            @(posedge clk_sys) #2;
        end
    endtask
    task t_refused;
        word = {3'h3, 1'b0, 3'h0, 7'h05};
        rd = 8'hFE;
        instr_valid = 1;
        @(posedge clk_sys) #2 chk("discard", dc, 1);
        word = {7'h03, 7'h11};
        @(posedge clk_sys) #2 chk("nop_exec", no_operation, 1);
        chk("slot_we", we, 0);
        chk("slot_zero", zs, 0);
        @(posedge clk_sys) #2 chk("after_we", we, 1);
        instr_valid = 0;
        @(posedge clk_sys) #2 chk("idle_we", we, 0);
    endtask
    task t_other;
        issue(14'h0103, 8'h00);
        chk("other_we", we, 0);
        chk("other_zero", zs, 0);
        chk("other_disc", dc, 0);
        @(posedge clk_sys) #2;
    endtask
    task t_reset;
        issue({3'h3, 1'b1, 3'h2, 7'h09}, 8'h04);
        chk("discard", dc, 1);
        reset = 1;
        #1 chk("rst_disc", dc, 0);
        chk("rst_busy", bsy, 0);
        @(posedge clk_sys) #2 reset = 0;
        @(posedge clk_sys) #2 chk("rst_nop", no_operation, 0);
        chk("rst_we", we, 0);
    endtask
    task t_clear(input logic [6:0] a);
        issue({7'h03, a}, 8'h5A);
        chk("file_we", we, 1);
        chk("file_waddr", wa, a);
        chk("file_wdata", wd, 0);
        chk("zero_set", zs, 1);
        @(posedge clk_sys) #2 chk("we_end", we, 0);
        chk("zero_end", zs, 0);
    endtask
    task complete_run;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #2 reset = 0;
        @(posedge clk_sys) #2;
        chk("init_disc", dc, 0);
        chk("init_we", we, 0);
        chk("init_zero", zs, 0);
        t_skip(0);
        t_skip(1);
        t_clear(7'h00);
        t_clear(7'h7F);
        t_refused;
        t_other;
        t_reset;
        complete_run();
    end
endmodule
`default_nettype wire
